// ---- common/divide_pkg.sv ----
package divide_pkg;
  // instruction word fields
  localparam int MODE_MSB = 15;
  localparam int MODE_LSB = 14;
  localparam int OPC_MSB = 13;
  localparam int OPC_LSB = 8;
  localparam int SRC_MSB = 7;
  localparam int SRC_LSB = 4;
  localparam int DST_MSB = 3;
  localparam int DST_LSB = 0;
  localparam logic [1:0] MODE_IMM = 2'h0;
  localparam logic [1:0] MODE_EAM = 2'h1;
  localparam logic [1:0] MODE_REG = 2'h2;
  localparam logic [5:0] OPC_WORD = 6'h1b;
  localparam logic [5:0] OPC_LONG = 6'h1a;
  localparam logic [3:0] SRC_NONE = 4'h0;
  localparam logic [1:0] EXT_MIN = 2'h1;
  localparam logic [1:0] EXT_MAX = 2'h3;
  localparam int WORD_W = 16;
  localparam int LONG_W = 32;
  // reset values
  localparam logic [63:0] RESULT_RST = 64'h0000_0000_0000_0000;
  localparam logic [3:0] FLAGS_RST = 4'h0;
  localparam logic [1:0] EXT_COUNT_RST = 2'h0;

  typedef enum logic [2:0] {
    FORM_REG = 3'h0,
    FORM_IMM = 3'h1,
    FORM_IND = 3'h3,
    FORM_EAM = 3'h2,
    FORM_BAD = 3'h6
  } form_t;

  typedef struct packed {
    logic c;
    logic z;
    logic s;
    logic v;
  } flags_t;

  typedef struct packed {
    logic valid;
    logic is_signed;
    logic is_long;
    logic [63:0] dividend;
    logic [31:0] divisor;
  } div_req_t;

  typedef struct packed {
    logic valid;
    logic write_dst;
    logic [63:0] result;
    flags_t flags;
    logic trap;
  } div_rsp_t;

  typedef struct packed {
    logic valid;
    form_t form;
    logic is_long;
    logic [3:0] src_field;
    logic [3:0] dst_field;
    logic [1:0] data_words;
  } dec_t;
endpackage

// ---- design/integer_divide_unit.sv ----
`timescale 1ns/1ps
module integer_divide_unit
  import divide_pkg::*;
(
  // clock and reset
  input wire logic core_clk,
  input wire logic rst_b,
  // instruction decode
  input wire logic [15:0] instr_word,
  input wire logic instr_valid,
  input wire logic [1:0] ext_words,
  output dec_t decode,
  // divide request and result
  input div_req_t req,
  input wire logic trap_enable,
  output div_rsp_t rsp
);

  // decoder fields
  wire logic [1:0] mode = instr_word[MODE_MSB:MODE_LSB];
  wire logic [5:0] opc = instr_word[OPC_MSB:OPC_LSB];
  wire logic [3:0] srcf = instr_word[SRC_MSB:SRC_LSB];
  wire logic [3:0] dstf = instr_word[DST_MSB:DST_LSB];
  wire logic opc_ok = (opc == OPC_WORD) || (opc == OPC_LONG);
  wire logic is_long_op = (opc == OPC_LONG);
  wire logic ext_ok = (ext_words >= EXT_MIN) && (ext_words <= EXT_MAX);
  // long immediate brings high then low data word, word form one
  wire logic [1:0] imm_words = is_long_op ? 2'h2 : 2'h1;
  wire form_t dec_form =
    !opc_ok ? FORM_BAD :
    (mode == MODE_REG) ? FORM_REG :
    (mode == MODE_IMM && srcf == SRC_NONE) ? FORM_IMM :
    (mode == MODE_IMM) ? FORM_IND :
    (mode == MODE_EAM && ext_ok) ? FORM_EAM : FORM_BAD;
  wire logic [1:0] dec_words =
    (dec_form == FORM_IMM) ? imm_words :
    (dec_form == FORM_EAM) ? ext_words : 2'h0;

  // decode register, data out from flops
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      decode <= '0;
    end else begin
      decode.valid <= instr_valid && (dec_form != FORM_BAD);
      decode.form <= dec_form;
      decode.is_long <= is_long_op;
      decode.src_field <= srcf;
      decode.dst_field <= dstf; // quad legality is the issuer's job
      decode.data_words <= dec_words;
    end
  end

  // operand sign handling; unsigned path uses raw magnitudes
  wire logic [63:0] dvd_w = req.is_long ? req.dividend : {32'h0000_0000, req.dividend[31:0]};
  wire logic [31:0] dvs_w = req.is_long ? req.divisor : {16'h0000, req.divisor[15:0]};
  wire logic dvd_neg = req.is_signed && (req.is_long ? dvd_w[63] : dvd_w[31]);
  wire logic dvs_neg = req.is_signed && (req.is_long ? dvs_w[31] : dvs_w[15]);
  wire logic [63:0] dvd_mag = dvd_neg ?
    (req.is_long ? 64'(-dvd_w) : {32'h0000_0000, 32'(-dvd_w[31:0])}) : dvd_w;
  wire logic [31:0] dvs_mag = dvs_neg ?
    (req.is_long ? 32'(-dvs_w) : {16'h0000, 16'(-dvs_w[15:0])}) : dvs_w;

  // combinational magnitude divide, single cycle; area traded for latency
  wire logic div_zero = (dvs_mag == 32'h0000_0000);
  wire logic [63:0] q_mag = div_zero ? 64'h0000_0000_0000_0000 : dvd_mag / {32'h0000_0000, dvs_mag};
  wire logic [63:0] r_mag = div_zero ? 64'h0000_0000_0000_0000 : dvd_mag % {32'h0000_0000, dvs_mag};
  wire logic q_neg = dvd_neg ^ dvs_neg;
  wire logic [63:0] q_val = q_neg ? 64'(-q_mag) : q_mag;
  wire logic [63:0] r_val = dvd_neg ? 64'(-r_mag) : r_mag; // remainder follows dividend sign

  // outcome classification; width of the quotient field is 16 or 32
  wire logic [63:0] half_lim = req.is_long ? 64'h0000_0001_0000_0000 : 64'h0000_0000_0001_0000;
  wire logic [63:0] sgn_lim = {1'b0, half_lim[63:1]};
  wire logic q_over_u = (q_mag >= half_lim);
  // signed fits: -(2^n-1 +1) < q < 2^n-1
  wire logic q_fits_s = q_neg ? (q_mag <= sgn_lim) : (q_mag < sgn_lim);
  wire logic case_zero = div_zero;
  wire logic case_over = req.is_signed ? !case_zero && q_over_u : !case_zero && q_over_u;
  wire logic case_fit = !case_zero && !case_over && (req.is_signed ? q_fits_s : 1'b1);
  wire logic case_part = req.is_signed && !case_zero && !case_over && !q_fits_s;

  // quotient field views
  wire logic [31:0] q_field = req.is_long ? q_val[31:0] : {16'h0000, q_val[15:0]};
  // zero, and the signed sign, judged on the true quotient; unsigned sign is the field's top bit;
  // a signed partial quotient like +2^15 must not read as negative
  wire logic q_is_zero = (q_mag == 64'h0000_0000_0000_0000);
  wire logic q_sign = req.is_signed ? (q_neg && !q_is_zero) : (req.is_long ? q_val[31] : q_val[15]);
  // partial case keeps all but the sign bit of the quotient
  wire logic [31:0] q_part = req.is_long ? {1'b0, q_val[30:0]} : {16'h0000, 1'b0, q_val[14:0]};

  // result packing: remainder high half, quotient low half
  wire logic [63:0] res_long = {r_val[31:0], case_part ? q_part : q_field};
  wire logic [63:0] res_word = {32'h0000_0000, r_val[15:0], case_part ? q_part[15:0] : q_field[15:0]};
  wire logic [63:0] next_result = req.is_long ? res_long : res_word;

  // flags per case
  wire flags_t next_flags = '{
    c: case_part,
    z: case_zero || ((case_fit || case_part) && q_is_zero),
    s: (case_fit || case_part) && q_sign,
    v: !case_fit
  };
  wire logic next_write = case_fit || case_part;

  // result register; divisor is only read, never written back
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      rsp <= '{valid: 1'b0, write_dst: 1'b0, result: RESULT_RST, flags: FLAGS_RST, trap: 1'b0};
    end else begin
      rsp.valid <= req.valid;
      rsp.write_dst <= req.valid && next_write;
      rsp.result <= next_result;
      rsp.flags <= next_flags;
      rsp.trap <= req.valid && next_flags.v && trap_enable;
    end
  end

  // checks
  a_zero_div_flags: assert property (@(posedge core_clk) disable iff (!rst_b)
    req.valid && div_zero |=> rsp.flags.v && rsp.flags.z && !rsp.flags.c && !rsp.flags.s && !rsp.write_dst)
    else $error("zero divisor flags wrong");
  a_carry_partial: assert property (@(posedge core_clk) disable iff (!rst_b)
    req.valid && !req.is_signed |=> !rsp.flags.c)
    else $error("carry set on unsigned divide");
  a_fit_no_v: assert property (@(posedge core_clk) disable iff (!rst_b)
    rsp.valid && rsp.write_dst && !rsp.flags.c |-> !rsp.flags.v)
    else $error("overflow set on fitting quotient");
  a_partial_flags: assert property (@(posedge core_clk) disable iff (!rst_b)
    rsp.valid && rsp.flags.c |-> rsp.flags.v && !rsp.flags.z && rsp.write_dst)
    else $error("partial case flags wrong");
  a_over_no_write: assert property (@(posedge core_clk) disable iff (!rst_b)
    rsp.valid && rsp.flags.v && !rsp.flags.c |-> !rsp.write_dst)
    else $error("destination written on overflow");
  a_trap_request: assert property (@(posedge core_clk) disable iff (!rst_b)
    rsp.trap == (rsp.valid && rsp.flags.v && $past(trap_enable)))
    else $error("trap request mismatch");
  a_unsigned_word: assert property (@(posedge core_clk) disable iff (!rst_b)
    req.valid && !req.is_signed && !req.is_long && next_write
    |=> rsp.result[15:0] == 16'($past(req.dividend[31:0]) / {16'h0000, $past(req.divisor[15:0])}))
    else $error("unsigned word quotient wrong");
  a_unsigned_rem: assert property (@(posedge core_clk) disable iff (!rst_b)
    req.valid && !req.is_signed && !req.is_long && next_write
    |=> rsp.result[31:16] == 16'($past(req.dividend[31:0]) % {16'h0000, $past(req.divisor[15:0])}))
    else $error("unsigned word remainder wrong");
  a_sign_cleared: assert property (@(posedge core_clk) disable iff (!rst_b)
    rsp.valid && !rsp.write_dst |-> !rsp.flags.s)
    else $error("sign set without result");
  a_imm_words: assert property (@(posedge core_clk) disable iff (!rst_b)
    instr_valid && mode == MODE_IMM && srcf == SRC_NONE && opc_ok
    |=> decode.form == FORM_IMM && decode.data_words == (decode.is_long ? 2'h2 : 2'h1))
    else $error("immediate decode wrong");

  // outcome classes never overlap
  a_cases_onehot: assert property (@(posedge core_clk) disable iff (!rst_b)
    req.valid |-> $onehot({case_zero, case_over, case_fit, case_part}))
    else $error("outcome cases overlap");
  // unsigned has no partial-result case
  a_unsigned_three: assert property (@(posedge core_clk) disable iff (!rst_b)
    req.valid && !req.is_signed |-> !case_part)
    else $error("partial case on unsigned divide");
  // every request answered one cycle later
  a_valid_pulse: assert property (@(posedge core_clk) disable iff (!rst_b)
    req.valid |=> rsp.valid)
    else $error("response missing");
  // idle cycles leave the destination and trap alone
  a_idle_quiet: assert property (@(posedge core_clk) disable iff (!rst_b)
    !req.valid |=> !rsp.valid && !rsp.write_dst && !rsp.trap)
    else $error("response without request");
  // zero divisor: z and v set, c and s clear, and no write
  a_zero_no_write: assert property (@(posedge core_clk) disable iff (!rst_b)
    req.valid && div_zero |=> !rsp.write_dst && rsp.flags == 4'h5)
    else $error("zero divisor result wrong");
  // overflow: only v set, destination kept
  a_over_flags: assert property (@(posedge core_clk) disable iff (!rst_b)
    req.valid && case_over |=> !rsp.write_dst && rsp.flags == 4'h1)
    else $error("overflow case flags wrong");
  // fitting quotient clears v and c and writes
  a_fit_flags_cv: assert property (@(posedge core_clk) disable iff (!rst_b)
    req.valid && case_fit |=> !rsp.flags.v && !rsp.flags.c && rsp.write_dst)
    else $error("fit case flags wrong");
  // zero quotient gives z
  a_fit_zero_flag: assert property (@(posedge core_clk) disable iff (!rst_b)
    req.valid && case_fit && q_mag == 64'h0000_0000_0000_0000 |=> rsp.flags.z)
    else $error("zero flag missing");
  // nonzero quotient clears z
  a_fit_nonzero: assert property (@(posedge core_clk) disable iff (!rst_b)
    req.valid && case_fit && q_mag != 64'h0000_0000_0000_0000 |=> !rsp.flags.z)
    else $error("zero flag on nonzero quotient");
  // negative signed quotient shows in s
  a_neg_sign: assert property (@(posedge core_clk) disable iff (!rst_b)
    req.valid && req.is_signed && (case_fit || case_part) && q_neg && q_mag != 64'h0000_0000_0000_0000
    |=> rsp.flags.s)
    else $error("sign flag missing");
  // positive signed quotient, even when truncated, clears s
  a_pos_sign: assert property (@(posedge core_clk) disable iff (!rst_b)
    req.valid && req.is_signed && (case_fit || case_part) && !q_neg |=> !rsp.flags.s)
    else $error("sign flag on positive quotient");
  // cases 1 and 2 clear s
  a_over_sign: assert property (@(posedge core_clk) disable iff (!rst_b)
    req.valid && (case_zero || case_over) |=> !rsp.flags.s)
    else $error("sign flag on unwritten result");
  // partial case flags
  a_part_zero_clear: assert property (@(posedge core_clk) disable iff (!rst_b)
    req.valid && case_part |=> !rsp.flags.z && rsp.flags.c && rsp.flags.v)
    else $error("partial flags wrong");
  // partial word quotient drops its sign bit
  a_part_sign_word: assert property (@(posedge core_clk) disable iff (!rst_b)
    req.valid && case_part && !req.is_long |=> !rsp.result[15])
    else $error("partial word sign bit kept");
  // partial long quotient drops its sign bit
  a_part_sign_long: assert property (@(posedge core_clk) disable iff (!rst_b)
    req.valid && case_part && req.is_long |=> !rsp.result[31])
    else $error("partial long sign bit kept");
  // partial word case keeps the full remainder
  a_part_rem: assert property (@(posedge core_clk) disable iff (!rst_b)
    req.valid && case_part && !req.is_long |=> rsp.result[31:16] == $past(r_val[15:0]))
    else $error("partial remainder wrong");
  // word form leaves the upper result word clear
  a_word_upper_zero: assert property (@(posedge core_clk) disable iff (!rst_b)
    req.valid && !req.is_long |=> rsp.result[63:32] == 32'h0000_0000)
    else $error("word result upper half set");
  // unsigned long quotient
  a_long_quot: assert property (@(posedge core_clk) disable iff (!rst_b)
    req.valid && !req.is_signed && req.is_long && case_fit
    |=> rsp.result[31:0] == 32'($past(req.dividend) / {32'h0000_0000, $past(req.divisor)}))
    else $error("unsigned long quotient wrong");
  // unsigned long remainder
  a_long_rem: assert property (@(posedge core_clk) disable iff (!rst_b)
    req.valid && !req.is_signed && req.is_long && case_fit
    |=> rsp.result[63:32] == 32'($past(req.dividend) % {32'h0000_0000, $past(req.divisor)}))
    else $error("unsigned long remainder wrong");
  // unsigned operands never negated
  a_unsigned_raw: assert property (@(posedge core_clk) disable iff (!rst_b)
    req.valid && !req.is_signed |-> !dvd_neg && !dvs_neg)
    else $error("unsigned operand negated");
  // unsigned long fit stays within 32 bits
  a_long_bounds: assert property (@(posedge core_clk) disable iff (!rst_b)
    req.valid && req.is_long && case_fit && !req.is_signed |-> q_mag < 64'h0000_0001_0000_0000)
    else $error("long fit out of range");
  // unsigned word fit stays within 16 bits
  a_word_bounds: assert property (@(posedge core_clk) disable iff (!rst_b)
    req.valid && !req.is_long && case_fit && !req.is_signed |-> q_mag < 64'h0000_0000_0001_0000)
    else $error("word fit out of range");
  // fitting word quotient lands in the low half
  a_fit_quot_word: assert property (@(posedge core_clk) disable iff (!rst_b)
    req.valid && case_fit && !req.is_long |=> rsp.result[15:0] == $past(q_val[15:0]))
    else $error("word quotient misplaced");
  // trap raised on divide by zero when enabled
  a_trap_on_zero: assert property (@(posedge core_clk) disable iff (!rst_b)
    req.valid && div_zero && trap_enable |=> rsp.trap)
    else $error("trap missing on zero divisor");
  // trap raised on overflow when enabled
  a_trap_on_over: assert property (@(posedge core_clk) disable iff (!rst_b)
    req.valid && case_over && trap_enable |=> rsp.trap)
    else $error("trap missing on overflow");
  // no trap when the quotient fits
  a_no_trap_fit: assert property (@(posedge core_clk) disable iff (!rst_b)
    req.valid && case_fit |=> !rsp.trap)
    else $error("trap on fitting quotient");
  // no trap while traps are disabled
  a_trap_needs_en: assert property (@(posedge core_clk) disable iff (!rst_b)
    req.valid && !trap_enable |=> !rsp.trap)
    else $error("trap while disabled");

  // decoder forms
  a_eam_words: assert property (@(posedge core_clk) disable iff (!rst_b)
    instr_valid && mode == MODE_EAM && opc_ok && ext_words != 2'h0
    |=> decode.valid && decode.form == FORM_EAM && decode.data_words == $past(ext_words))
    else $error("address form decode wrong");
  // address form with no extension word refused
  a_eam_none: assert property (@(posedge core_clk) disable iff (!rst_b)
    instr_valid && mode == MODE_EAM && ext_words == 2'h0 |=> !decode.valid)
    else $error("address form without extension accepted");
  // long immediate brings two data words
  a_long_imm: assert property (@(posedge core_clk) disable iff (!rst_b)
    instr_valid && mode == MODE_IMM && srcf == SRC_NONE && opc == OPC_LONG
    |=> decode.valid && decode.is_long && decode.data_words == 2'h2)
    else $error("long immediate decode wrong");
  // register form
  a_reg_form: assert property (@(posedge core_clk) disable iff (!rst_b)
    instr_valid && mode == MODE_REG && opc_ok |=> decode.valid && decode.form == FORM_REG)
    else $error("register form decode wrong");
  // indirect form
  a_ind_form: assert property (@(posedge core_clk) disable iff (!rst_b)
    instr_valid && mode == MODE_IMM && srcf != SRC_NONE && opc_ok |=> decode.valid && decode.form == FORM_IND)
    else $error("indirect form decode wrong");
  // unknown opcode refused
  a_bad_opcode: assert property (@(posedge core_clk) disable iff (!rst_b)
    instr_valid && !opc_ok |=> !decode.valid)
    else $error("unknown opcode accepted");
  // register fields passed through untouched
  a_dec_fields: assert property (@(posedge core_clk) disable iff (!rst_b)
    instr_valid |=> decode.dst_field == $past(dstf) && decode.src_field == $past(srcf))
    else $error("register fields wrong");
endmodule // integer_divide_unit

// ---- tb/integer_divide_unit_tb.sv ----
`timescale 1ns/1ps
module integer_divide_unit_tb;
  import divide_pkg::*;
  logic core_clk;
  logic rst_b;
  logic [15:0] instr_word;
  logic instr_valid;
  logic [1:0] ext_words;
  dec_t decode;
  div_req_t req;
  logic trap_enable;
  div_rsp_t rsp;
  int fails;
  int checked;

  integer_divide_unit dut_u (.core_clk(core_clk), .rst_b(rst_b), .instr_word(instr_word),
    .instr_valid(instr_valid), .ext_words(ext_words), .decode(decode), .req(req),
    .trap_enable(trap_enable), .rsp(rsp));

  // 25 MHz core clock
  initial begin
    core_clk = 1'b0;
    forever #20 core_clk = ~core_clk;
  end

  task automatic final_report();
    if (fails == 0 && checked > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  task automatic bad(input string msg);
    fails++;
    $display("wrong value at %0t: %s", $time, msg);
  endtask

  // one request; answer judged after the next edge, flags as {c,z,s,v}
  task automatic divide(input logic sg, input logic lg, input logic te, input logic [63:0] dd,
      input logic [31:0] dv, input logic wr, input logic [63:0] res, input logic [3:0] fl);
    @(posedge core_clk);
    req <= '{valid: 1'b1, is_signed: sg, is_long: lg, dividend: dd, divisor: dv};
    trap_enable <= te;
    @(posedge core_clk);
    #1;
    checked++;
    if (rsp.valid !== 1'b1 || rsp.write_dst !== wr || rsp.flags !== fl || rsp.trap !== (fl[0] & te))
      bad("divide flags");
    // word form only defines the low 32 bits of the result
    if (wr && (lg ? rsp.result !== res : rsp.result[31:0] !== res[31:0]))
      bad("divide result");
  endtask

  task automatic dec(input logic [15:0] w, input logic [1:0] ex, input logic ok, input form_t f,
      input logic lg, input logic [1:0] nw);
    @(posedge core_clk);
    instr_word <= w;
    instr_valid <= 1'b1;
    ext_words <= ex;
    @(posedge core_clk);
    #1;
    checked++;
    if (decode.valid !== ok || decode.form !== f || (ok && decode.is_long !== lg))
      bad("decode form");
    if (decode.dst_field !== w[3:0] || decode.src_field !== w[7:4])
      bad("decode fields");
    if (ok && (f == FORM_IMM || f == FORM_EAM) && decode.data_words !== nw)
      bad("decode words");
  endtask

  task automatic signed_cases();
    divide(1, 0, 0, 64'h0000_0000_0000_0022, 32'h0000_0006, 1, 64'h0000_0000_0004_0005, 4'h0);
    divide(1, 0, 0, 64'h0000_0000_FFFF_FFDE, 32'h0000_0006, 1, 64'h0000_0000_FFFC_FFFB, 4'h2);
    divide(1, 0, 1, 64'h0000_0000_0000_0022, 32'h0000_0000, 0, '0, 4'h5);
    divide(1, 0, 0, 64'h0000_0000_0020_0000, 32'h0000_0001, 0, '0, 4'h1);
    divide(1, 0, 1, 64'h0000_0000_0000_8000, 32'h0000_0001, 1, 64'h0000_0000_0000_0000, 4'h9);
    divide(1, 0, 0, 64'h0000_0000_FFFF_8000, 32'h0000_0001, 1, 64'h0000_0000_0000_8000, 4'h2);
    divide(1, 1, 0, 64'hFFFF_FFFF_FFFF_FFF9, 32'h0000_0002, 1, 64'hFFFF_FFFF_FFFF_FFFD, 4'h2);
  endtask

  task automatic unsigned_cases();
    divide(0, 0, 0, 64'h0000_0000_0000_FFFE, 32'h0000_FFFF, 1, 64'h0000_0000_FFFE_0000, 4'h4);
    divide(0, 0, 0, 64'h0000_0000_0001_FFFF, 32'h0000_0002, 1, 64'h0000_0000_0001_FFFF, 4'h2);
    divide(0, 0, 1, 64'h0000_0000_0002_0000, 32'h0000_0002, 0, '0, 4'h1);
    divide(0, 0, 1, 64'h0000_0000_0002_0000, 32'h0000_0000, 0, '0, 4'h5);
    divide(0, 1, 0, 64'h0000_0001_0000_0003, 32'h0000_0002, 1, 64'h0000_0001_8000_0001, 4'h2);
    divide(0, 1, 0, 64'h0000_0002_0000_0000, 32'h0000_0002, 0, '0, 4'h1);
    divide(0, 0, 0, 64'h0000_0000_FFFF_FFFF, 32'h0001_FFFF, 0, '0, 4'h1);
  endtask

  task automatic decoder_forms();
    dec(16'h1B01, 2'h0, 1, FORM_IMM, 0, 2'h1);
    dec(16'h1A04, 2'h0, 1, FORM_IMM, 1, 2'h2);
    dec(16'h5B31, 2'h1, 1, FORM_EAM, 0, 2'h1);
    dec(16'h5A34, 2'h3, 1, FORM_EAM, 1, 2'h3);
    dec(16'h5B31, 2'h0, 0, FORM_BAD, 0, 2'h0);
    dec(16'h9B31, 2'h0, 1, FORM_REG, 0, 2'h0);
    dec(16'h1A34, 2'h0, 1, FORM_IND, 1, 2'h0);
    dec(16'h1C01, 2'h0, 0, FORM_BAD, 0, 2'h0);
  endtask

  // reset held 20 cycles, then each group of scenarios in turn
  initial begin
    fails = 0;
    checked = 0;
    rst_b = 1'b0;
    instr_word = '0;
    instr_valid = 1'b0;
    ext_words = '0;
    req = '0;
    trap_enable = 1'b0;
    repeat (20) @(posedge core_clk);
    rst_b <= 1'b1;
    signed_cases();
    unsigned_cases();
    decoder_forms();
    final_report();
  end

  // about 64 cycles expected, reset included; far more means a hang
  initial begin
    #20000;
    bad("watchdog expired");
    final_report();
  end
endmodule // integer_divide_unit_tb
